// File: usrc_defs.vh
// Purpose: Constants for the UART shadow control register block.
// Assumes: Byte addresses on a 32-bit plain register port.
// Notes:   Base register addresses end 0x7c bytes below the shadow group.
`ifndef USRC_DEFS_VH
`define USRC_DEFS_VH

// ***************************************************************
// Register byte addresses
// ***************************************************************
`define USRC_ADDR_FIFO_CTRL 32'h50001108
`define USRC_ADDR_LINE_CTRL 32'h5000110c
`define USRC_ADDR_MODEM_CTRL 32'h50001110
`define USRC_ADDR_SHADOW_RTS 32'h5000118c
`define USRC_ADDR_SHADOW_BREAK 32'h50001190
`define USRC_ADDR_SHADOW_DMA 32'h50001194

// ***************************************************************
// Field positions
// ***************************************************************
`define USRC_MCR_RTS 1
`define USRC_MCR_LOOP 4
`define USRC_MCR_AFCE 5
`define USRC_MCR_SIR 6
`define USRC_LCR_BREAK 6
`define USRC_FCR_FIFO_EN 0
`define USRC_FCR_DMA_MODE 3
`define USRC_FCR_TRIG_LO 6
`define USRC_FCR_TRIG_HI 7
`define USRC_SHADOW_BIT 0

// Writable bits of each base register; the rest read as zero
`define USRC_MCR_MASK 8'h7f
`define USRC_LCR_MASK 8'hff
`define USRC_FCR_MASK 8'hf9

// ***************************************************************
// Reset values and FIFO figures
// ***************************************************************
`define USRC_REG_RESET 8'h00
`define USRC_LVL_W 5
`define USRC_FIFO_DEPTH 5'h10
`define USRC_TRIG_ONE 5'h01
`define USRC_TRIG_QUARTER 5'h04
`define USRC_TRIG_HALF 5'h08
`define USRC_TRIG_NEAR_FULL 5'h0e
`define USRC_NO_FIFO_DEPTH 5'h01
`define USRC_SIR_DIV 4'hf
`define USRC_CNT_ZERO 4'h0

`endif

// File: usrc_shadow_regs.v
// Purpose: Shadow control bits of a UART controller and their effect on
//          request-to-send, serial, infrared and DMA request outputs.
// Assumes: One 25 MHz clock; all inputs synchronous to it; FIFOs of 16.
// Notes:   Every output is registered, so pins follow state by one cycle.
`timescale 1ns/1ps
`include "usrc_defs.vh"

module usrc_shadow_regs (
   input wire i_mclk,
   input wire i_reset_n,
   input wire [31:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [31:0] o_rdata,
   input wire [4:0] i_rx_fifo_level,
   input wire [4:0] i_tx_fifo_level,
   input wire i_tx_sout,
   input wire i_tx_sir_n,
   input wire i_sin,
   output reg o_rts_n,
   output reg o_sout,
   output reg o_sir_out_n,
   output reg o_rx_sin,
   output reg o_loop_cts,
   output reg o_dma_tx_req_n,
   output reg o_dma_rx_req_n,
   output reg o_fifo_en,
   output reg o_dma_mode
);

   // ***************************************************************
   // Reset release
   // ***************************************************************
   reg rst_sync1_r;
   reg rst_n_r;

   always @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_sync1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_sync1_r <= 1'b1;
         rst_n_r <= rst_sync1_r;
      end
   end

   // ***************************************************************
   // Control state
   // ***************************************************************
   // Each shadow location is only another door onto one bit of these
   // registers, so both paths land in a single flip-flop.
   reg [7:0] modem_control_reg_r;
   reg [7:0] line_control_reg_r;
   reg [7:0] fifo_control_reg_r;
   reg [7:0] modem_control_reg_nxt;
   reg [7:0] line_control_reg_nxt;
   reg [7:0] fifo_control_reg_nxt;

   wire wr_mcr = i_wr && (i_addr == `USRC_ADDR_MODEM_CTRL);
   wire wr_lcr = i_wr && (i_addr == `USRC_ADDR_LINE_CTRL);
   wire wr_fcr = i_wr && (i_addr == `USRC_ADDR_FIFO_CTRL);
   wire wr_srts = i_wr && (i_addr == `USRC_ADDR_SHADOW_RTS);
   wire wr_sbcr = i_wr && (i_addr == `USRC_ADDR_SHADOW_BREAK);
   wire wr_sdma = i_wr && (i_addr == `USRC_ADDR_SHADOW_DMA);

   always @* begin
      modem_control_reg_nxt = modem_control_reg_r;
      line_control_reg_nxt = line_control_reg_r;
      fifo_control_reg_nxt = fifo_control_reg_r;
      if (wr_mcr) begin
         modem_control_reg_nxt = i_wdata[7:0] & `USRC_MCR_MASK;
      end
      if (wr_lcr) begin
         line_control_reg_nxt = i_wdata[7:0] & `USRC_LCR_MASK;
      end
      if (wr_fcr) begin
         fifo_control_reg_nxt = i_wdata[7:0] & `USRC_FCR_MASK;
      end
      if (wr_srts) begin
         modem_control_reg_nxt[`USRC_MCR_RTS] =
            i_wdata[`USRC_SHADOW_BIT];
      end
      if (wr_sbcr) begin
         line_control_reg_nxt[`USRC_LCR_BREAK] =
            i_wdata[`USRC_SHADOW_BIT];
      end
      if (wr_sdma) begin
         fifo_control_reg_nxt[`USRC_FCR_DMA_MODE] =
            i_wdata[`USRC_SHADOW_BIT];
      end
   end

   always @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         modem_control_reg_r <= `USRC_REG_RESET;
         line_control_reg_r <= `USRC_REG_RESET;
         fifo_control_reg_r <= `USRC_REG_RESET;
      end else begin
         modem_control_reg_r <= modem_control_reg_nxt;
         line_control_reg_r <= line_control_reg_nxt;
         fifo_control_reg_r <= fifo_control_reg_nxt;
      end
   end

   wire rts_bit = modem_control_reg_r[`USRC_MCR_RTS];
   wire loop_mode = modem_control_reg_r[`USRC_MCR_LOOP];
   wire afc_en = modem_control_reg_r[`USRC_MCR_AFCE];
   wire sir_mode = modem_control_reg_r[`USRC_MCR_SIR];
   wire brk_bit = line_control_reg_r[`USRC_LCR_BREAK];
   wire fifo_en = fifo_control_reg_r[`USRC_FCR_FIFO_EN];
   wire dma_mode = fifo_control_reg_r[`USRC_FCR_DMA_MODE];
   wire [1:0] trig_sel =
      fifo_control_reg_r[`USRC_FCR_TRIG_HI:`USRC_FCR_TRIG_LO];

   // ***************************************************************
   // Register read port
   // ***************************************************************
   reg [31:0] rdata_nxt;

   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (i_addr)
         `USRC_ADDR_MODEM_CTRL: begin
            rdata_nxt[7:0] = modem_control_reg_r;
         end
         `USRC_ADDR_LINE_CTRL: begin
            rdata_nxt[7:0] = line_control_reg_r;
         end
         `USRC_ADDR_FIFO_CTRL: begin
            rdata_nxt[7:0] = fifo_control_reg_r;
         end
         `USRC_ADDR_SHADOW_RTS: begin
            rdata_nxt[`USRC_SHADOW_BIT] = rts_bit;
         end
         `USRC_ADDR_SHADOW_BREAK: begin
            rdata_nxt[`USRC_SHADOW_BIT] = brk_bit;
         end
         `USRC_ADDR_SHADOW_DMA: begin
            rdata_nxt[`USRC_SHADOW_BIT] = dma_mode;
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // Data stand for exactly the cycle after the read strobe
   always @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         o_rdata <= rdata_nxt;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // ***************************************************************
   // Receive threshold
   // ***************************************************************
   reg [4:0] rx_thresh;

   always @* begin
      case (trig_sel)
         2'b00: rx_thresh = `USRC_TRIG_ONE;
         2'b01: rx_thresh = `USRC_TRIG_QUARTER;
         2'b10: rx_thresh = `USRC_TRIG_HALF;
         2'b11: rx_thresh = `USRC_TRIG_NEAR_FULL;
         default: rx_thresh = `USRC_TRIG_ONE;
      endcase
   end

   wire rx_above = (i_rx_fifo_level > rx_thresh);
   wire rx_at_trig = (i_rx_fifo_level >= rx_thresh);

   // ***************************************************************
   // Request-to-send pin
   // ***************************************************************
   reg rts_n_nxt;

   always @* begin
      if (loop_mode) begin
         rts_n_nxt = 1'b1;
      end else if (afc_en && fifo_en && rx_above) begin
         rts_n_nxt = 1'b1;
      end else begin
         rts_n_nxt = ~rts_bit;
      end
   end

   // ***************************************************************
   // Infrared break pulse
   // ***************************************************************
   // A held level on the infrared pin would read as idle, so break is
   // sent as a steady pulse train from a free divider.
   reg [3:0] sir_cnt_r;
   reg sir_pulse_r;
   wire sir_tick = (sir_cnt_r == `USRC_SIR_DIV);

   always @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sir_cnt_r <= `USRC_CNT_ZERO;
         sir_pulse_r <= 1'b1;
      end else begin
         if (sir_tick) begin
            sir_cnt_r <= `USRC_CNT_ZERO;
         end else begin
            sir_cnt_r <= sir_cnt_r + 4'h1;
         end
         if (!(sir_mode && brk_bit)) begin
            sir_pulse_r <= 1'b1;
         end else if (sir_tick) begin
            sir_pulse_r <= ~sir_pulse_r;
         end
      end
   end

   // ***************************************************************
   // Serial, loopback and infrared paths
   // ***************************************************************
   reg sout_nxt;
   reg rx_sin_nxt;
   reg sir_nxt;

   always @* begin
      if (loop_mode) begin
         sout_nxt = 1'b1;
         sir_nxt = 1'b1;
         rx_sin_nxt = brk_bit ? 1'b0 : i_tx_sout;
      end else begin
         sout_nxt = brk_bit ? 1'b0 : i_tx_sout;
         sir_nxt = (sir_mode && brk_bit) ? sir_pulse_r : i_tx_sir_n;
         rx_sin_nxt = i_sin;
      end
   end

   // ***************************************************************
   // DMA requests
   // ***************************************************************
   // With FIFOs off there is a single holding slot, so mode 1 reduces
   // to the mode 0 conditions.
   reg tx_req_nxt;
   reg rx_req_nxt;
   wire tx_empty = (i_tx_fifo_level == 5'h00);
   wire rx_has = (i_rx_fifo_level != 5'h00);
   wire [4:0] tx_cap = fifo_en ? `USRC_FIFO_DEPTH : `USRC_NO_FIFO_DEPTH;

   always @* begin
      if (dma_mode && fifo_en) begin
         tx_req_nxt = (i_tx_fifo_level < tx_cap);
         rx_req_nxt = rx_at_trig;
      end else begin
         tx_req_nxt = tx_empty;
         rx_req_nxt = rx_has;
      end
   end

   // ***************************************************************
   // Output flip-flops
   // ***************************************************************
   always @(posedge i_mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_rts_n <= 1'b1;
         o_sout <= 1'b1;
         o_sir_out_n <= 1'b1;
         o_rx_sin <= 1'b1;
         o_loop_cts <= 1'b0;
         o_dma_tx_req_n <= 1'b1;
         o_dma_rx_req_n <= 1'b1;
         o_fifo_en <= 1'b0;
         o_dma_mode <= 1'b0;
      end else begin
         o_rts_n <= rts_n_nxt;
         o_sout <= sout_nxt;
         o_sir_out_n <= sir_nxt;
         o_rx_sin <= rx_sin_nxt;
         o_loop_cts <= loop_mode & rts_bit;
         o_dma_tx_req_n <= ~tx_req_nxt;
         o_dma_rx_req_n <= ~rx_req_nxt;
         o_fifo_en <= fifo_en;
         o_dma_mode <= dma_mode;
      end
   end

endmodule // usrc_shadow_regs

// File: usrc_shadow_chk.sv
// Purpose: Port assertions for the shadow control register block.
// Assumes: Design leaves reset two edges after release.
// Notes:   Checks start two edges later so $past sees live state.
`timescale 1ns/1ps
`include "usrc_defs.vh"
module usrc_shadow_chk (
   input wire i_mclk,
   input wire i_reset_n,
   input wire [31:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [31:0] o_rdata,
   input wire [4:0] i_tx_fifo_level,
   input wire o_rts_n,
   input wire o_sout,
   input wire o_rx_sin,
   input wire o_loop_cts,
   input wire o_dma_tx_req_n,
   input wire o_fifo_en,
   input wire o_dma_mode
);
   // Pins carry reset values until one edge after the design wakes,
   // so checking waits for the fourth edge after release.
   reg [3:0] live_r;
   always @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) live_r <= 4'h0;
      else live_r <= {live_r[2:0], 1'b1};
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!live_r[3]);
   loop_rts_high_a: assert property (o_loop_cts |-> o_rts_n)
      else $error("rts pin active in loopback");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read slot");
   shadow_upper_a: assert property ($past(i_rd) &&
      $past(i_addr) - `USRC_ADDR_SHADOW_RTS <= 32'h8 |->
      o_rdata[31:1] == 31'h0) else $error("shadow upper bits set");
   rts_alias_a: assert property (i_wr &&
      i_addr == `USRC_ADDR_SHADOW_RTS ##1 i_rd &&
      i_addr == `USRC_ADDR_MODEM_CTRL |=> o_rdata[1] ==
      $past(i_wdata[0], 2)) else $error("rts alias lost");
   dma_pin_a: assert property (i_wr &&
      i_addr == `USRC_ADDR_SHADOW_DMA ##1 !i_wr |=>
      o_dma_mode == $past(i_wdata[0], 2)) else $error("dma mode pin");
   fifo_en_pin_a: assert property (i_wr &&
      i_addr == `USRC_ADDR_FIFO_CTRL ##1 !i_wr |=>
      o_fifo_en == $past(i_wdata[0], 2)) else $error("fifo enable pin");
   break_out_a: assert property (i_wr && i_wdata[0] &&
      i_addr == `USRC_ADDR_SHADOW_BREAK ##1 !i_wr |=>
      !o_sout || !o_rx_sin) else $error("break not applied");
   dma_tx_mode0_a: assert property (!o_dma_mode |->
      o_dma_tx_req_n == ($past(i_tx_fifo_level) != 5'h0))
      else $error("mode 0 transmit request");
endmodule // usrc_shadow_chk

// File: usrc_modem_model.sv
// Purpose: Modem at the far end of the serial line.
// Assumes: It sends only while request-to-send is active.
// Notes:   A stalled modem leaves the line at mark.
`timescale 1ns/1ps
module usrc_modem_model (
   input wire i_mclk,
   input wire i_rts_n,
   input wire i_sout,
   output reg o_sin = 1'b1,
   output reg [7:0] o_space_cnt = 8'h00
);
   // Length of the current spacing run shows a held break
   always @(posedge i_mclk) begin
      o_sin <= i_rts_n ? 1'b1 : ~o_sin;
      o_space_cnt <= i_sout ? 8'h0 : o_space_cnt + 8'h1;
   end
endmodule // usrc_modem_model

// File: uart_shadow_ctrl_regs_tb.sv
// Purpose: Self-checking bench for the shadow control registers.
// Assumes: Pins follow a register write two edges later.
// Notes:   Reset reads first, then alias rows, then pin behaviour by hand.
`timescale 1ns/1ps
`include "usrc_defs.vh"
module uart_shadow_ctrl_regs_tb;
   localparam [31:0] a_fc = `USRC_ADDR_FIFO_CTRL;
   localparam [31:0] a_lc = `USRC_ADDR_LINE_CTRL;
   localparam [31:0] a_mc = `USRC_ADDR_MODEM_CTRL;
   localparam [31:0] a_rts = `USRC_ADDR_SHADOW_RTS;
   localparam [31:0] a_brk = `USRC_ADDR_SHADOW_BREAK;
   localparam [31:0] a_dma = `USRC_ADDR_SHADOW_DMA;
   reg i_mclk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   reg [31:0] i_addr = 32'h0, i_wdata = 32'h0, got;
   reg [4:0] i_rx_fifo_level = 5'h0, i_tx_fifo_level = 5'h0;
   reg i_tx_sout = 1'b1, i_tx_sir_n = 1'b1;
   wire [31:0] o_rdata;
   wire [7:0] space_cnt;
   wire i_sin, o_rts_n, o_sout, o_sir_out_n, o_rx_sin, o_loop_cts;
   wire o_dma_tx_req_n, o_dma_rx_req_n, o_fifo_en, o_dma_mode;
   integer mismatches = 0, comparisons = 0, i, n;
   // Row: write address and data, read address, bit to look at, value
   typedef struct packed {
      logic [31:0] wa;
      logic [31:0] wd;
      logic [31:0] ra;
      logic [4:0] b;
      logic e;
   } usrc_row_t;
   usrc_row_t rows [0:6];
   usrc_shadow_regs u_usrc_shadow_regs (.i_mclk, .i_reset_n, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rx_fifo_level,
      .i_tx_fifo_level, .i_tx_sout, .i_tx_sir_n, .i_sin, .o_rts_n,
      .o_sout, .o_sir_out_n, .o_rx_sin, .o_loop_cts, .o_dma_tx_req_n,
      .o_dma_rx_req_n, .o_fifo_en, .o_dma_mode);
   usrc_modem_model u_usrc_modem_model (.i_mclk, .i_rts_n(o_rts_n),
      .i_sout(o_sout), .o_sin(i_sin), .o_space_cnt(space_cnt));
   initial forever #20 i_mclk = ~i_mclk;
   task wr(input [31:0] a, d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      repeat (2) @(posedge i_mclk);
   endtask
   task rd(input [31:0] a);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(posedge i_mclk);
      got = o_rdata;
   endtask
   task chk(input logic [31:0] g, e);
      comparisons = comparisons + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge i_mclk);
      mismatches = mismatches + 1;
      results;
   end
   // ******************
   // Main sequence
   // ******************
   initial begin
      rows[0] = {a_rts, 32'h1, a_mc, 5'h01, 1'b1};
      rows[1] = {a_mc, 32'h0, a_rts, 5'h00, 1'b0};
      rows[2] = {a_brk, 32'h1, a_lc, 5'h06, 1'b1};
      rows[3] = {a_lc, 32'h0, a_brk, 5'h00, 1'b0};
      rows[4] = {a_dma, 32'h1, a_fc, 5'h03, 1'b1};
      rows[5] = {a_fc, 32'h0, a_dma, 5'h00, 1'b0};
      rows[6] = {a_fc, 32'h8, a_dma, 5'h00, 1'b1};
      repeat (2) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      for (i = 0; i < 3; i = i + 1) begin
         rd(a_rts + 4 * i);
         chk(got, 32'h0);
      end
      chk({o_rts_n, o_dma_mode}, 2'b10);
      for (i = 0; i < 7; i = i + 1) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra);
         chk(got[rows[i].b], rows[i].e);
      end
      i_addr <= a_rts;
      i_wdata <= 32'hffffffff;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      rd(a_mc);
      chk(got, 32'h2);
      rd(a_rts);
      chk(got, 32'h1);
      chk(o_rts_n, 1'b0);
      wr(a_rts + 32'hc, 32'hff);
      rd(a_rts + 32'hc);
      chk(got, 32'h0);
      wr(a_mc, 32'h22);
      for (i = 0; i < 4; i = i + 1) begin
         wr(a_fc, {i[1:0], 6'h01});
         n = (i == 3) ? 14 : (i == 0) ? 1 : 4 * i;
         i_rx_fifo_level <= n[4:0];
         repeat (2) @(posedge i_mclk);
         chk(o_rts_n, 1'b0);
         i_rx_fifo_level <= n[4:0] + 5'h1;
         repeat (2) @(posedge i_mclk);
         chk(o_rts_n, 1'b1);
      end
      wr(a_fc, 32'hc0);
      chk({o_rts_n, o_fifo_en}, 2'b00);
      wr(a_fc, 32'h89);
      i_tx_fifo_level <= 5'h3;
      i_rx_fifo_level <= 5'h7;
      repeat (2) @(posedge i_mclk);
      chk({o_dma_tx_req_n, o_dma_rx_req_n}, 2'b01);
      i_rx_fifo_level <= 5'h8;
      repeat (2) @(posedge i_mclk);
      chk({o_dma_tx_req_n, o_dma_rx_req_n}, 2'b00);
      wr(a_dma, 32'h0);
      chk({o_dma_tx_req_n, o_dma_rx_req_n}, 2'b10);
      wr(a_mc, 32'h12);
      chk({o_rts_n, o_loop_cts}, 2'b11);
      wr(a_brk, 32'h1);
      chk({o_sout, o_rx_sin}, 2'b10);
      wr(a_mc, 32'h0);
      repeat (10) @(posedge i_mclk);
      chk({o_sout, space_cnt >= 8'h0a}, 2'b01);
      wr(a_lc, 32'h0);
      chk(o_sout, 1'b1);
      // Idle level alone cannot show that transmission resumed
      i_tx_sout <= 1'b0;
      repeat (2) @(posedge i_mclk);
      chk(o_sout, 1'b0);
      i_tx_sout <= 1'b1;
      wr(a_mc, 32'h42);
      i_tx_sir_n <= 1'b0;
      repeat (2) @(posedge i_mclk);
      chk(o_sir_out_n, 1'b0);
      i_tx_sir_n <= 1'b1;
      wr(a_brk, 32'h1);
      got[1:0] = {o_rx_sin, o_sir_out_n};
      n = 0;
      i = 0;
      repeat (40) begin
         @(posedge i_mclk);
         if (o_sir_out_n !== got[0]) n = n + 1;
         if (o_rx_sin !== got[1]) i = i + 1;
         got[1:0] = {o_rx_sin, o_sir_out_n};
      end
      chk({n >= 2, i >= 30}, 2'b11);
      // Mid-run reset: pins go idle at once, every control bit clears
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_mclk);
      got = {23'h000000, o_rts_n, o_sout, o_sir_out_n, o_rx_sin,
         o_loop_cts, o_dma_tx_req_n, o_dma_rx_req_n, o_fifo_en,
         o_dma_mode};
      chk(got, 32'h1ec);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rd(a_mc);
      chk(got, 32'h0);
      rd(a_rts);
      chk(got, 32'h0);
      results;
   end
endmodule // uart_shadow_ctrl_regs_tb
bind usrc_shadow_regs usrc_shadow_chk u_usrc_shadow_chk (.i_mclk,
   .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .i_tx_fifo_level, .o_rts_n, .o_sout, .o_rx_sin, .o_loop_cts,
   .o_dma_tx_req_n, .o_fifo_en, .o_dma_mode);
